// ### design/sysref_cfg_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          serial configuration bank for the SYSREF control block.
// Assumes: Byte-wide registers on a 15-bit serial address.
// Notes:   Definitions only; included by bare name.
`ifndef SYSREF_CFG_DEFINES_SVH
`define SYSREF_CFG_DEFINES_SVH

// =====================================================================
// Register offsets (byte addresses on the serial port)
`define OFS_MAKER_ID_LO     15'h000C
`define OFS_MAKER_ID_HI     15'h000D
`define OFS_USER_SERIAL_CFG 15'h0010
`define OFS_SYSREF_CLK_CTRL 15'h0029
`define OFS_EDGE_POS_B0     15'h002C
`define OFS_EDGE_POS_B1     15'h002D
`define OFS_EDGE_POS_B2     15'h002E

// =====================================================================
// Fixed values and reset values
`define MAKER_ID_VALUE      16'h5A5A  // Arbitrary neutral code
`define USER_SERIAL_CFG_RST 8'h00
`define SYSREF_CLK_CTRL_RST 8'h00

// =====================================================================
// Field positions
`define BIT_ADDR_FREEZE     0
`define BIT_PROC_EN         6
`define BIT_RECV_EN         5
`define BIT_FINE_WINDOW     4
`define SEL_MSB             3
`define SEL_LSB             0

// =====================================================================
// Frame counts: 16 header bits, 8 bits a data byte
`define HDR_LAST_BIT        4'hF
`define BYTE_LAST_BIT       4'h7

`endif

// ### design/sysref_cfg_pkg.sv
// Purpose: Types shared by the serial engine and the register bank.
// Assumes: Constants live in the defines header.
// Notes:   Enum codes are written out.
package sysref_cfg_pkg;

  // ===================================================================
  // Serial frame phases
  typedef enum logic [1:0]
  {
    PH_IDLE   = 2'b00,
    PH_HEADER = 2'b01,
    PH_WRITE  = 2'b10,
    PH_READ   = 2'b11
  } phase_t;

  typedef logic [14:0] reg_addr_t;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [23:0] edge_pos_t;

endpackage : sysref_cfg_pkg

// ### design/reg_access_if.sv
// Purpose: Byte access path from the serial engine to the register bank.
// Assumes: Single core clock on both sides.
// Notes:   Write is a one-cycle strobe; read data is combinational.
interface reg_access_if;
  import sysref_cfg_pkg::*;

  logic      wr_en;
  reg_addr_t wr_addr;
  reg_byte_t wr_data;
  reg_addr_t rd_addr;
  reg_byte_t rd_data;

  modport engine
  (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input  rd_data
  );

  modport bank
  (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    output rd_data
  );
endinterface : reg_access_if

// ### design/sysref_reg_bank.sv
// Purpose: Maker code, user serial config and SYSREF clock control.
// Assumes: Writes arrive as one-cycle strobes from the serial engine.
// Notes:   Unmapped addresses read zero and ignore writes.
`include "sysref_cfg_defines.svh"

module sysref_reg_bank
  import sysref_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Access path
  reg_access_if.bank      acc,
  // Device side
  input  wire edge_pos_t  i_edge_position,
  output logic            o_addr_freeze,
  output logic [7:0]      o_clk_ctrl
);

  logic      freeze_r;
  logic [6:0] clk_ctrl_r;
  edge_pos_t edge_pos_r;

  // Constants held at their own width; a bare literal cannot be sliced
  localparam logic [15:0] MAKER_CODE = `MAKER_ID_VALUE;
  localparam logic [7:0]  USER_RST   = `USER_SERIAL_CFG_RST;
  localparam logic [7:0]  CTRL_RST   = `SYSREF_CLK_CTRL_RST;

  // ===================================================================
  // Writable state; reserved bits are not stored and read as zero
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      freeze_r <= USER_RST[`BIT_ADDR_FREEZE];                      // [R02]
    else if (acc.wr_en && acc.wr_addr == `OFS_USER_SERIAL_CFG)
      freeze_r <= acc.wr_data[`BIT_ADDR_FREEZE];
  end

  // Clock control: receiver, processor, fine window, delay select
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      clk_ctrl_r <= CTRL_RST[6:0];                                 // [R05]
    else if (acc.wr_en && acc.wr_addr == `OFS_SYSREF_CLK_CTRL)
      clk_ctrl_r <= acc.wr_data[6:0];                  // [R06] [R07] [R11]
  end

  // Edge position is registered so reads see a stable byte
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      edge_pos_r <= '0;
    else
      edge_pos_r <= i_edge_position;                               // [R15]
  end

  // ===================================================================
  // Read decode; maker code has no write path at all
  always_comb
  begin
    case (acc.rd_addr)
      `OFS_MAKER_ID_LO:     acc.rd_data = MAKER_CODE[7:0];       // [R01]
      `OFS_MAKER_ID_HI:     acc.rd_data = MAKER_CODE[15:8];      // [R16]
      `OFS_USER_SERIAL_CFG: acc.rd_data = {7'h00, freeze_r};
      `OFS_SYSREF_CLK_CTRL: acc.rd_data = {1'b0, clk_ctrl_r};
      `OFS_EDGE_POS_B0:     acc.rd_data = edge_pos_r[7:0];
      `OFS_EDGE_POS_B1:     acc.rd_data = edge_pos_r[15:8];
      `OFS_EDGE_POS_B2:     acc.rd_data = edge_pos_r[23:16];
      default:              acc.rd_data = 8'h00;
    endcase
  end

  assign o_addr_freeze = freeze_r;
  assign o_clk_ctrl    = {1'b0, clk_ctrl_r};

endmodule : sysref_reg_bank

// ### design/spi_config_sysref_control.sv
// Purpose: Serial configuration port with the SYSREF control registers.
// Assumes: Serial clock half period of at least three core clocks.
// Notes:   Frame is R/W bit, 15-bit address, then streamed data bytes.
//
// Functional notes
// R01: Maker identification is 16 bits, read only, always the fixed code.
// R02: User serial config at 0x10 resets to 0x00; bits 7..1 reserved.
// R03: Freeze bit clear: streaming address steps per direction setting.
// R04: Freeze bit set: address stays fixed for the whole stream.
// R05: Clock control register resets to 0x00; bit 7 reserved.
// R06: Bit 5 enables the SYSREF receiver; off after reset.
// R07: Bit 6 enables the SYSREF processor; off after reset.
// R08: Host enables the receiver before the processor.
// R09: Bit 4 selects finer SYSREF window delay steps.
// R10: Host sets fine window at high rates with multiple valid windows.
// R11: Bits 3..0 select the SYSREF capture delay.
// R12: Host picks delay select from the edge position readback.
// R13: Host leaves delay select at zero for automatic calibration.
// R14: Direction 1 increments, 0 decrements; increment by default.
// R15: A 24-bit edge position status is readable.
// R16: Writes to the maker code are ignored without side effects.
`include "sysref_cfg_defines.svh"

module spi_config_sysref_control
(
  // Clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  // Serial configuration pins
  input  wire logic                   i_spi_sclk,
  input  wire logic                   i_spi_cs_n,
  input  wire logic                   i_spi_sdi,
  output logic                        o_spi_sdo,
  output logic                        o_spi_sdo_oe,
  // Address direction from the device configuration
  input  wire logic                   i_addr_ascend,
  // SYSREF datapath
  input  wire sysref_cfg_pkg::edge_pos_t i_sysref_edge_position,
  output logic                        o_sysref_receiver_enable,
  output logic                        o_sysref_processor_enable,
  output logic                        o_sysref_fine_window,
  output logic [3:0]                  o_sysref_delay_select,
  output logic                        o_sysref_auto_cal_ok
);
  import sysref_cfg_pkg::*;

  // ===================================================================
  // Declarations
  logic [1:0] sclk_sync_r;
  logic [1:0] csn_sync_r;
  logic [1:0] sdi_sync_r;
  logic       sclk_prev_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;
  logic       sdi_bit;
  phase_t     phase_r;
  logic [3:0] bit_cnt_r;
  logic [14:0] shift_r;
  reg_addr_t  addr_r;
  reg_addr_t  addr_nxt;
  logic       wr_en_r;
  reg_addr_t  wr_addr_r;
  reg_byte_t  wr_data_r;
  logic       load_pend_r;
  reg_byte_t  tx_r;
  logic       sdo_r;
  logic       addr_freeze;
  logic [7:0] clk_ctrl;
  logic       hdr_done;
  logic       byte_done;

  reg_access_if acc ();

  // ===================================================================
  // Pin synchronisers; only stage 2 ([1]) is looked at by logic
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      sclk_sync_r <= 2'h0;
      csn_sync_r  <= 2'h3;
      sdi_sync_r  <= 2'h0;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      sclk_sync_r <= {sclk_sync_r[0], i_spi_sclk};
      csn_sync_r  <= {csn_sync_r[0], i_spi_cs_n};
      sdi_sync_r  <= {sdi_sync_r[0], i_spi_sdi};
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  // Edges seen on the synchronised serial clock
  assign sclk_rise = sclk_sync_r[1] & ~sclk_prev_r;
  assign sclk_fall = ~sclk_sync_r[1] & sclk_prev_r;
  assign cs_act    = ~csn_sync_r[1];
  assign sdi_bit   = sdi_sync_r[1];
  assign hdr_done  = (phase_r == PH_HEADER) && sclk_rise &&
                     (bit_cnt_r == `HDR_LAST_BIT);
  assign byte_done = ((phase_r == PH_WRITE) || (phase_r == PH_READ)) &&
                     sclk_rise && (bit_cnt_r == `BYTE_LAST_BIT);

  // ===================================================================
  // Streaming address step: hold, increment or decrement
  always_comb
  begin
    if (addr_freeze)
      addr_nxt = addr_r;                                           // [R04]
    else if (i_addr_ascend)
      addr_nxt = reg_addr_t'(addr_r + 15'h0001);             // [R03] [R14]
    else
      addr_nxt = reg_addr_t'(addr_r - 15'h0001);                   // [R14]
  end

  // ===================================================================
  // Frame phase and bit counter; chip select high aborts any frame
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !cs_act)
    begin
      phase_r   <= PH_IDLE;
      bit_cnt_r <= 4'h0;
    end
    else
    begin
      case (phase_r)
        PH_IDLE:
          phase_r <= PH_HEADER;
        PH_HEADER:
          if (sclk_rise)
          begin
            bit_cnt_r <= hdr_done ? 4'h0 : bit_cnt_r + 4'h1;
            if (hdr_done)
              phase_r <= shift_r[14] ? PH_READ : PH_WRITE;
          end
        PH_WRITE, PH_READ:
          if (sclk_rise)
            bit_cnt_r <= byte_done ? 4'h0 : bit_cnt_r + 4'h1;
        default:
          phase_r <= PH_IDLE;
      endcase
    end
  end

  // Input shifter, MSB first
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      shift_r <= 15'h0000;
    else if (cs_act && sclk_rise)
      shift_r <= {shift_r[13:0], sdi_bit};
  end

  // ===================================================================
  // Address: loaded from the header, stepped after each data byte
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      addr_r <= 15'h0000;
    else if (cs_act && hdr_done)
      addr_r <= {shift_r[13:0], sdi_bit};
    else if (cs_act && byte_done)
      addr_r <= addr_nxt;                                    // [R03] [R04]
  end

  // Write strobe carries the address of the byte just received
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      wr_en_r   <= 1'b0;
      wr_addr_r <= 15'h0000;
      wr_data_r <= 8'h00;
    end
    else
    begin
      wr_en_r <= cs_act && byte_done && (phase_r == PH_WRITE);
      if (byte_done)
      begin
        wr_addr_r <= addr_r;
        wr_data_r <= {shift_r[6:0], sdi_bit};
      end
    end
  end

  // ===================================================================
  // Read path: fetch one cycle after the address settles, shift out on
  // falling serial edges so the host samples on the rising edge
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !cs_act)
      load_pend_r <= 1'b0;
    else
      load_pend_r <= hdr_done ? shift_r[14] :
                     (byte_done && phase_r == PH_READ);
  end

  // Load wins over shift; the clock period bound keeps them apart
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      tx_r  <= 8'h00;
      sdo_r <= 1'b0;
    end
    else if (load_pend_r)
      tx_r <= acc.rd_data;
    else if (phase_r == PH_READ && sclk_fall)
    begin
      sdo_r <= tx_r[7];
      tx_r  <= {tx_r[6:0], 1'b0};
    end
  end

  assign acc.wr_en   = wr_en_r;
  assign acc.wr_addr = wr_addr_r;
  assign acc.wr_data = wr_data_r;
  assign acc.rd_addr = addr_r;

  // ===================================================================
  // Register bank
  sysref_reg_bank u_bank
  (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .acc             (acc.bank),
    .i_edge_position (i_sysref_edge_position),
    .o_addr_freeze   (addr_freeze),
    .o_clk_ctrl      (clk_ctrl)
  );

  // ===================================================================
  // Outputs; processor enable is passed as written since the host
  // orders it after the receiver
  assign o_spi_sdo    = sdo_r;
  assign o_spi_sdo_oe = (phase_r == PH_READ);
  assign o_sysref_receiver_enable  = clk_ctrl[`BIT_RECV_EN];        // [R06]
  assign o_sysref_processor_enable = clk_ctrl[`BIT_PROC_EN];   // [R07] [R08]
  assign o_sysref_fine_window      = clk_ctrl[`BIT_FINE_WINDOW];    // [R09]
  assign o_sysref_delay_select     = clk_ctrl[`SEL_MSB:`SEL_LSB];   // [R11]
  // Automatic calibration only runs while delay select is zero
  assign o_sysref_auto_cal_ok =
    (clk_ctrl[`SEL_MSB:`SEL_LSB] == 4'h0);                          // [R13]

endmodule : spi_config_sysref_control

// ### sim/spi_config_sysref_control_chk.sv
// Purpose: Port-level assertions for the SYSREF control block.
// Assumes: One core clock; synchronous active-high reset.
// Notes:   Bound to the top module at the foot of this file.
module spi_config_sysref_control_chk
(
  // Clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  // Watched pins
  input wire logic       i_spi_cs_n,
  input wire logic       o_spi_sdo_oe,
  input wire logic       o_sysref_receiver_enable,
  input wire logic       o_sysref_processor_enable,
  input wire logic       o_sysref_fine_window,
  input wire logic [3:0] o_sysref_delay_select,
  input wire logic       o_sysref_auto_cal_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // ==================================================================
  // Control bits gathered for compact comparisons
  wire logic [6:0] ctrl_w = {o_sysref_processor_enable,
    o_sysref_receiver_enable, o_sysref_fine_window, o_sysref_delay_select};

  // First frame starts three clocks after release at the earliest
  sequence rst_done;
    $fell(i_rst);
  endsequence
  // Six idle clocks cover the pin synchroniser and the write strobe
  sequence bus_idle;
    i_spi_cs_n [*6];
  endsequence

  // ==================================================================
  // Reset values, auto calibration flag and idle behaviour
  ctrl_reset_a: assert property
    (rst_done |-> ctrl_w == 7'h00) else $error("control not cleared");
  recv_off_a: assert property
    (rst_done |-> !o_sysref_receiver_enable [*3]) else $error("recv on");
  proc_off_a: assert property
    (rst_done |-> !o_sysref_processor_enable [*3]) else $error("proc on");
  fine_off_a: assert property
    (rst_done |-> !o_sysref_fine_window [*3]) else $error("fine on");
  sel_zero_a: assert property
    (rst_done |-> (o_sysref_delay_select == 4'h0) [*3])
    else $error("delay select not zero");
  auto_cal_a: assert property
    (o_sysref_auto_cal_ok == (o_sysref_delay_select == 4'h0))
    else $error("auto cal flag wrong");
  ctrl_hold_a: assert property
    (bus_idle |-> $stable(ctrl_w)) else $error("control moved when idle");
  oe_idle_a: assert property
    (bus_idle |-> !o_spi_sdo_oe) else $error("sdo driven when idle");
endmodule : spi_config_sysref_control_chk

bind spi_config_sysref_control spi_config_sysref_control_chk chk_inst
(
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_spi_cs_n(i_spi_cs_n),
  .o_spi_sdo_oe(o_spi_sdo_oe),
  .o_sysref_receiver_enable(o_sysref_receiver_enable),
  .o_sysref_processor_enable(o_sysref_processor_enable),
  .o_sysref_fine_window(o_sysref_fine_window),
  .o_sysref_delay_select(o_sysref_delay_select),
  .o_sysref_auto_cal_ok(o_sysref_auto_cal_ok)
);

// ### sim/spi_host_model.sv
// Purpose: Serial host that frames register reads and writes.
// Assumes: Six core clocks each sclk half period, above the minimum.
// Notes:   Data bytes go out highest byte first.
module spi_host_model
(
  // Clock and return data
  input  wire logic i_core_clk,
  input  wire logic i_spi_sdo,
  // Serial pins
  output logic      o_spi_sclk,
  output logic      o_spi_cs_n,
  output logic      o_spi_sdi
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_spi_sclk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_sdi  = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : hold

  // One frame: R/W bit, address, nb data bytes; sdo taken before rises
  task automatic frame(input logic rd, input logic [14:0] a,
    input int nb, input logic [31:0] wd, output logic [31:0] q);
    logic [15:0] hdr;
    hdr = {rd, a};
    q = 32'h0;
    o_spi_cs_n = 1'b0;
    hold(4);
    for (int i = 0; i < 16 + 8 * nb; i++)
    begin
      o_spi_sdi = (i < 16) ? hdr[15 - i] : wd[8 * nb + 15 - i];
      hold(6);
      if (i >= 16)
        q = {q[30:0], i_spi_sdo};
      o_spi_sclk = 1'b1;
      hold(6);
      o_spi_sclk = 1'b0;
    end
    hold(6);
    o_spi_cs_n = 1'b1;
    // Released data line must not look like a held value
    o_spi_sdi = ~o_spi_sdi;
    // Gap long enough for the idle-bus checks to see a quiet port
    hold(8);
  endtask : frame
endmodule : spi_host_model

// ### sim/spi_config_sysref_control_bench.sv
// Purpose: Self-checking bench for the SYSREF control registers.
// Assumes: Host model drives pins on core clock falling edges.
// Notes:   Expected values come from the register definitions.
`include "sysref_cfg_defines.svh"
module spi_config_sysref_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sysref_cfg_pkg::*;

  logic        clk, rst, sclk, cs_n, sdi, sdo, asc;
  logic        recv, proc, fine, acal, oe;
  logic [3:0]  sel;
  edge_pos_t   pos;
  logic [31:0] rd;
  logic [15:0] mk;
  int          fails, n_tests, oe_cyc;

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Counts core cycles with the data output enabled
  always @(posedge clk)
    if (oe === 1'b1)
      oe_cyc++;

  spi_config_sysref_control spi_config_sysref_control_inst
  (
    .i_core_clk(clk), .i_rst(rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
    .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe), .i_addr_ascend(asc),
    .i_sysref_edge_position(pos), .o_sysref_receiver_enable(recv),
    .o_sysref_processor_enable(proc), .o_sysref_fine_window(fine),
    .o_sysref_delay_select(sel), .o_sysref_auto_cal_ok(acal)
  );
  spi_host_model spi_host_model_inst
  (
    .i_core_clk(clk), .i_spi_sdo(sdo), .o_spi_sclk(sclk),
    .o_spi_cs_n(cs_n), .o_spi_sdi(sdi)
  );

  // ==================================================================
  // Comparison, access and closing tasks
  task automatic check(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wr(input logic [14:0] a, input int nb, input logic [31:0] d);
    spi_host_model_inst.frame(1'b0, a, nb, d, rd);
  endtask : wr
  task automatic rdb(input logic [14:0] a, input int nb,
    input logic [31:0] e, input string nm);
    int c0;
    c0 = oe_cyc;
    spi_host_model_inst.frame(1'b1, a, nb, 32'h0, rd);
    check(nm, rd, e);
    check("oe", {31'h0, oe_cyc != c0}, 32'h1);
  endtask : rdb
  task automatic outs(input logic [7:0] e);
    check("ctrl", {25'h0, proc, recv, fine, sel}, {24'h0, e});
    check("acal", {31'h0, acal}, {31'h0, e[3:0] == 4'h0});
  endtask : outs
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Hang guard: every frame is fixed length, so this only trips on a stall
  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    close_out;
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    asc = 1'b1;
    pos = 24'hC3A51E;
    mk = `MAKER_ID_VALUE;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    outs(8'h00);
    rdb(`OFS_USER_SERIAL_CFG, 1, 32'h00, "usr");
    rdb(`OFS_SYSREF_CLK_CTRL, 1, 32'h00, "ctl");
    rdb(`OFS_MAKER_ID_LO, 2, {16'h0, mk[7:0], mk[15:8]}, "id");
    wr(`OFS_MAKER_ID_LO, 2, 32'hA5C3);
    rdb(`OFS_MAKER_ID_LO, 2, {16'h0, mk[7:0], mk[15:8]}, "id");
    rdb(`OFS_SYSREF_CLK_CTRL, 1, 32'h00, "ctl");
    // Receiver goes on before the processor
    wr(`OFS_SYSREF_CLK_CTRL, 1, 32'h20);
    outs(8'h20);
    wr(`OFS_SYSREF_CLK_CTRL, 1, 32'h60);
    outs(8'h60);
    wr(`OFS_SYSREF_CLK_CTRL, 1, 32'h9F);
    outs(8'h1F);
    rdb(`OFS_SYSREF_CLK_CTRL, 1, 32'h1F, "ctl");
    rdb(`OFS_EDGE_POS_B0, 3, {8'h0, pos[7:0], pos[15:8], pos[23:16]},
      "pos");
    wr(`OFS_SYSREF_CLK_CTRL, 1, 32'h65);
    outs(8'h65);
    wr(`OFS_SYSREF_CLK_CTRL, 1, 32'h00);
    outs(8'h00);
    asc = 1'b0;
    rdb(`OFS_EDGE_POS_B2, 3, {8'h0, pos}, "down");
    asc = 1'b1;
    // Stream from an unmapped byte into the control register
    wr(15'h0028, 2, 32'h7734);
    outs(8'h34);
    rdb(15'h0028, 1, 32'h00, "gap");
    wr(`OFS_USER_SERIAL_CFG, 1, 32'hFF);
    rdb(`OFS_USER_SERIAL_CFG, 1, 32'h01, "usr");
    rdb(`OFS_EDGE_POS_B0, 3, {8'h0, {3{pos[7:0]}}}, "frz");
    wr(`OFS_SYSREF_CLK_CTRL, 2, 32'h2513);
    outs(8'h13);
    close_out;
  end
endmodule : spi_config_sysref_control_bench
